/* File: include/eoc_port_consts.svh */
// Constants for the end-of-conversion interrupt host port
`ifndef EOC_PORT_CONSTS_SVH
`define EOC_PORT_CONSTS_SVH
`define ADDR_LOW_BYTE    1'h0
`define ADDR_HIGH_BYTE   1'h1
`define OUT_LATCH_RESET  8'h00
`define PIE_MODE0_WORD   8'h99
`define HIGH_NIBBLE_POS  4
`define BUS_SYNC_RESET   12'he00
`define CONV_SYNC_RESET  13'h1000
`endif

/* File: include/eoc_port_pkg.sv */
// Types for the end-of-conversion interrupt host port
package eoc_port_pkg;
  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       sel_n;
    logic       a0;
    logic [7:0] wdata;
  } host_bus_type;
  typedef struct packed {
    logic       busy;
    logic [11:0] result;
  } conv_status_type;
  typedef enum logic [1:0] {
    xfer_idle,
    xfer_read,
    xfer_write
  } xfer_state_type;
endpackage

/* File: design/sync_two_ff.sv */
// Two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  // First stage only feeds the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // sync_two_ff
`default_nettype wire

/* File: design/eoc_interrupt_host_port.sv */
// End-of-conversion interrupt driven parallel host port
// Summary of operation
// R1: The interrupt latch sets on a rising edge of the conversion-complete status line.
// R2: The latch output drives the processor interrupt request directly, ungated.
// R3: A processor read of the status and upper result byte clears the latch.
// R4: The service routine must do that read before returning, else it re-enters.
// R5: The processor finishes its current instruction and then enters the service routine.
// R6: Only one such port drives the interrupt input; arbitration lives outside.
// R7: A parallel element replacing this logic is set to mode 0, port B out, rest in.
// R8: Any extra bus buffers are enabled by the same read and write strobes.
// R9: Strobes are honoured only while the address select is active.
// R10: On a read, the low address bit high selects the status and upper byte group.
// R11: Reset clears the interrupt latch.
`timescale 1ns/1ns
`default_nettype none
`include "eoc_port_consts.svh"
module eoc_interrupt_host_port (
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  input  wire eoc_port_pkg::host_bus_type    host_bus,
  input  wire eoc_port_pkg::conv_status_type conv_in,
  output var  logic [7:0]                    data_out,
  output logic [7:0]                         data_oe_n,
  output var  logic [7:0]                    port_b_output_lines,
  output logic                               ext_buf_rd_en,
  output logic                               ext_buf_wr_en,
  output logic                               irq
);
  import eoc_port_pkg::*;

  host_bus_type    bus_sync;
  conv_status_type conv_sync;
  xfer_state_type  state_reg;
  xfer_state_type  state_next;
  logic            status_last_reg;
  logic            int_latch_reg;
  logic            int_latch_next;
  logic [7:0]      read_mux;
  logic [7:0]      data_out_next;
  logic [7:0]      out_latch_next;

  // Host strobes and converter lines come from outside the clock
  // Reset to the idle bus so no false strobe follows reset
  sync_two_ff #(.WIDTH($bits(host_bus_type)), .RESET_VALUE(`BUS_SYNC_RESET)) u_sync_bus (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in (host_bus),
    .sync_out (bus_sync)
  );
  // Status resets high so a level held high gives no edge
  sync_two_ff #(.WIDTH($bits(conv_status_type)), .RESET_VALUE(`CONV_SYNC_RESET)) u_sync_conv (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in (conv_in),
    .sync_out (conv_sync)
  );

  // Strobe qualification by address select
  wire selected  = ~bus_sync.sel_n; // R9
  wire rd_active = selected & ~bus_sync.rd_n; // R9
  wire wr_active = selected & ~bus_sync.wr_n & bus_sync.rd_n; // R9
  wire rd_start  = rd_active & (state_reg != xfer_read);
  wire wr_start  = wr_active & (state_reg != xfer_write);
  wire eoc_rise  = conv_sync.busy & ~status_last_reg; // R1
  wire hi_read   = rd_start & (bus_sync.a0 == `ADDR_HIGH_BYTE); // R3

  // Byte group selection by low address bit
  assign read_mux = (bus_sync.a0 == `ADDR_HIGH_BYTE)
                  ? {int_latch_reg, 3'h0, conv_sync.result[11:8]} // R10
                  : conv_sync.result[7:0];

  // Transfer tracking so each strobe acts once
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      xfer_idle: begin
        if (rd_active) begin
          state_next = xfer_read;
        end else if (wr_active) begin
          state_next = xfer_write;
        end
      end
      xfer_read: begin
        if (!rd_active) begin
          state_next = wr_active ? xfer_write : xfer_idle;
        end
      end
      xfer_write: begin
        if (rd_active) begin
          state_next = xfer_read;
        end else if (!wr_active) begin
          state_next = xfer_idle;
        end
      end
      default: begin
        state_next = xfer_idle;
      end
    endcase
  end

  // Latch next value; a new edge wins over a clearing read
  assign int_latch_next = eoc_rise ? 1'b1 // R1
                        : (hi_read ? 1'b0 : int_latch_reg); // R3
  assign data_out_next  = rd_start ? read_mux : data_out;
  assign out_latch_next = wr_start ? bus_sync.wdata : port_b_output_lines;

  // Registered state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg           <= xfer_idle;
      status_last_reg     <= 1'b1; // No false edge after reset, R11
      int_latch_reg       <= 1'b0; // R11
      data_out            <= 8'h00;
      port_b_output_lines <= `OUT_LATCH_RESET;
    end else begin
      state_reg           <= state_next;
      status_last_reg     <= conv_sync.busy;
      int_latch_reg       <= int_latch_next;
      data_out            <= data_out_next;
      port_b_output_lines <= out_latch_next; // R9
    end
  end

  // Outputs
  assign irq           = int_latch_reg; // R2 R6
  assign data_oe_n     = (state_reg == xfer_read) ? 8'h00 : 8'hff;
  assign ext_buf_rd_en = (state_reg == xfer_read); // R8
  assign ext_buf_wr_en = (state_reg == xfer_write); // R8

  // Checks
  sequence s_rise;
    conv_sync.busy && !status_last_reg;
  endsequence
  chk_rise_sets_latch: assert property (@(posedge clk_sys) disable iff (srst) // R1
    s_rise |=> int_latch_reg) else $error("latch not set on rising status");
  chk_irq_follows_latch: assert property (@(posedge clk_sys) disable iff (srst) // R2
    irq == int_latch_reg) else $error("irq differs from latch");
  chk_hi_read_clears: assert property (@(posedge clk_sys) disable iff (srst) // R3
    hi_read && !eoc_rise |=> !int_latch_reg) else $error("high read did not clear latch");
  chk_latch_holds: assert property (@(posedge clk_sys) disable iff (srst) // R3
    !eoc_rise && !hi_read |=> int_latch_reg == $past(int_latch_reg))
    else $error("latch changed without cause");
  chk_unselected_quiet: assert property (@(posedge clk_sys) disable iff (srst) // R9
    bus_sync.sel_n && state_reg == xfer_idle |=> $stable(port_b_output_lines))
    else $error("port changed while unselected");
  chk_write_loads: assert property (@(posedge clk_sys) disable iff (srst) // R9
    wr_start |=> port_b_output_lines == $past(bus_sync.wdata))
    else $error("write did not load port");
  chk_low_byte_read: assert property (@(posedge clk_sys) disable iff (srst) // R10
    rd_start && bus_sync.a0 == `ADDR_LOW_BYTE |=> data_out == $past(conv_sync.result[7:0]))
    else $error("low byte read wrong");
  chk_buf_enables: assert property (@(posedge clk_sys) disable iff (srst) // R8
    ext_buf_rd_en |-> data_oe_n == 8'h00 && !ext_buf_wr_en)
    else $error("buffer enables disagree");
  chk_reset_clears: assert property (@(posedge clk_sys) // R11
    srst |=> !irq) else $error("reset left irq set");

  // Handshake sequences
  sequence s_read_taken;
    rd_start;
  endsequence
  sequence s_read_standing;
    ext_buf_rd_en && !ext_buf_wr_en && (data_oe_n == 8'h00);
  endsequence
  sequence s_write_taken;
    wr_start;
  endsequence
  sequence s_write_standing;
    ext_buf_wr_en && !ext_buf_rd_en && (data_oe_n == 8'hff);
  endsequence
  sequence s_clear_read;
    hi_read && !eoc_rise;
  endsequence
  sequence s_set_and_clear;
    hi_read && eoc_rise;
  endsequence

  // Read turns the data drivers on
  chk_read_drives_bus: assert property (@(posedge clk_sys) disable iff (srst) // R8
    s_read_taken |=> s_read_standing)
    else $error("read did not enable the data drivers");
  // Write keeps the data drivers off
  chk_write_no_drive: assert property (@(posedge clk_sys) disable iff (srst) // R8
    s_write_taken |=> s_write_standing)
    else $error("write enabled the data drivers");
  // Status byte carries the latch and upper bits
  chk_status_byte: assert property (@(posedge clk_sys) disable iff (srst) // R10
    s_clear_read |=> data_out == {$past(int_latch_reg), 3'h0,
                                  $past(conv_sync.result[11:8])})
    else $error("status byte read wrong");
  // New edge wins over a clearing read
  chk_set_beats_clear: assert property (@(posedge clk_sys) disable iff (srst) // R1
    s_set_and_clear |=> int_latch_reg)
    else $error("clear overrode a new edge");
  // No set without an edge
  chk_no_spurious_set: assert property (@(posedge clk_sys) disable iff (srst) // R1
    !int_latch_reg && !eoc_rise |=> !int_latch_reg)
    else $error("latch set without an edge");
  // Port only changes on a taken write
  chk_port_needs_write: assert property (@(posedge clk_sys) disable iff (srst) // R9
    !wr_start |=> $stable(port_b_output_lines))
    else $error("port changed without a write");
  // Read data holds between reads
  chk_data_holds: assert property (@(posedge clk_sys) disable iff (srst) // R10
    !rd_start |=> $stable(data_out))
    else $error("read data changed without a read");
  // Unselected bus starts nothing
  chk_unselected_no_xfer: assert property (@(posedge clk_sys) disable iff (srst) // R9
    bus_sync.sel_n && state_reg == xfer_idle |=> state_reg == xfer_idle)
    else $error("transfer started while unselected");
  // Drivers off outside a read
  chk_oe_outside_read: assert property (@(posedge clk_sys) disable iff (srst) // R8
    !ext_buf_rd_en |-> data_oe_n == 8'hff)
    else $error("data drivers on outside a read");
  // Reset leaves the port idle
  chk_reset_idle: assert property (@(posedge clk_sys) // R11
    srst |=> state_reg == xfer_idle && port_b_output_lines == `OUT_LATCH_RESET)
    else $error("reset left the port busy");

endmodule // eoc_interrupt_host_port
`default_nettype wire

/* File: verif/host_cpu_model.sv */
// Processor bus model that issues port reads and writes
`timescale 1ns/1ns
`default_nettype none
module host_cpu_model (
  input  wire logic                       clk_sys,
  input  wire logic                       rd_done,
  input  wire logic                       wr_done,
  input  wire logic [7:0]                 rdata,
  output var  eoc_port_pkg::host_bus_type bus
);
  import eoc_port_pkg::*;
  initial bus = '{rd_n: 1'h1, wr_n: 1'h1, sel_n: 1'h1, a0: 1'h0, wdata: 8'h00};
  // One transfer, held until the port answers or 8 cycles pass
  task automatic acc(input logic rd, input logic sel, input logic a0,
                     input logic [7:0] wd, output logic [7:0] q, output logic ok);
    int n;
    @(posedge clk_sys) #5;
    bus = '{rd_n: !rd, wr_n: rd, sel_n: !sel, a0: a0, wdata: wd};
    for (n = 0; n < 8 && (rd ? rd_done : wr_done) !== 1'b1; n++) @(posedge clk_sys) #1;
    ok = rd ? rd_done : wr_done;
    q = rdata;
    @(posedge clk_sys) #5;
    bus = '{rd_n: 1'h1, wr_n: 1'h1, sel_n: 1'h1, a0: !a0, wdata: ~wd};
    repeat (4) @(posedge clk_sys);
    #5;
  endtask
endmodule // host_cpu_model
`default_nettype wire

/* File: verif/tb_eoc_interrupt_host_port.sv */
// Testbench for the end-of-conversion interrupt host port
`timescale 1ns/1ns
`default_nettype none
`include "eoc_port_consts.svh"
module tb_eoc_interrupt_host_port;
  import eoc_port_pkg::*;
  logic            clk_sys = 1'b0;
  logic            srst = 1'b1;
  host_bus_type    host_bus;
  conv_status_type conv_in = '0;
  logic [7:0]      data_out, data_oe_n, port_b_output_lines, q;
  logic            ext_buf_rd_en, ext_buf_wr_en, irq, ok;
  int              fail_count = 0;
  int              comparisons = 0;
  always #25 clk_sys = ~clk_sys;
  eoc_interrupt_host_port u_eoc_interrupt_host_port (.clk_sys(clk_sys), .srst(srst),
    .host_bus(host_bus), .conv_in(conv_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .port_b_output_lines(port_b_output_lines), .ext_buf_rd_en(ext_buf_rd_en),
    .ext_buf_wr_en(ext_buf_wr_en), .irq(irq));
  host_cpu_model u_host_cpu_model (.clk_sys(clk_sys), .rd_done(ext_buf_rd_en),
    .wr_done(ext_buf_wr_en), .rdata(data_out), .bus(host_bus));
  // Compare one value and count it
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Wait up to 8 cycles for the request line
  task automatic wait_irq;
    for (int n = 0; n < 8 && irq !== 1'b1; n++) @(posedge clk_sys) #1;
  endtask
  task automatic t_bus;
    cmp("irq", 8'h00, {7'h00, irq});
    cmp("port_b", 8'h00, port_b_output_lines);
    cmp("oe_n", 8'hff, data_oe_n);
    cmp("mode0_word", 8'h99, `PIE_MODE0_WORD);
    u_host_cpu_model.acc(1'b0, 1'b1, 1'b0, 8'ha5, q, ok);
    cmp("wr_ok", 8'h01, {7'h00, ok});
    cmp("port_b", 8'ha5, port_b_output_lines);
    u_host_cpu_model.acc(1'b0, 1'b0, 1'b0, 8'h3c, q, ok);
    cmp("wr_unsel", 8'h00, {7'h00, ok});
    cmp("port_b", 8'ha5, port_b_output_lines);
    u_host_cpu_model.acc(1'b1, 1'b0, 1'b0, 8'h00, q, ok);
    cmp("rd_unsel", 8'h00, {7'h00, ok});
    conv_in.result = 12'h9c3;
    u_host_cpu_model.acc(1'b1, 1'b1, 1'b0, 8'h00, q, ok);
    cmp("rd_ok", 8'h01, {7'h00, ok});
    cmp("low_byte", 8'hc3, q);
    cmp("oe_idle", 8'hff, data_oe_n);
    $display("test bus done");
  endtask
  task automatic t_irq;
    @(posedge clk_sys) #5 conv_in.busy = 1'b1;
    wait_irq();
    cmp("irq_set", 8'h01, {7'h00, irq});
    u_host_cpu_model.acc(1'b1, 1'b1, 1'b0, 8'h00, q, ok);
    cmp("irq_low_rd", 8'h01, {7'h00, irq});
    u_host_cpu_model.acc(1'b1, 1'b1, 1'b1, 8'h00, q, ok);
    cmp("status", 8'h89, q);
    cmp("irq_clr", 8'h00, {7'h00, irq});
    @(posedge clk_sys) #5 conv_in.busy = 1'b0;
    repeat (6) @(posedge clk_sys);
    cmp("irq_fall", 8'h00, {7'h00, irq});
    @(posedge clk_sys) #5 conv_in.busy = 1'b1;
    wait_irq();
    cmp("irq_set2", 8'h01, {7'h00, irq});
    @(posedge clk_sys) #5 srst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #5 srst = 1'b0;
    repeat (6) @(posedge clk_sys);
    cmp("irq_rst", 8'h00, {7'h00, irq});
    $display("test irq done");
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    #5 srst = 1'b0;
    t_bus();
    t_irq();
    wrap_up();
  end
endmodule // tb_eoc_interrupt_host_port
`default_nettype wire
